// ---- rtl/srio_pkg.sv ----
package srio_pkg;

  // Clock and link-silence timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RX_TIMEOUT_US = 2000;
  localparam int unsigned RX_TIMEOUT_CYC = (CLK_HZ / 1_000_000) * RX_TIMEOUT_US;

  // Data and table geometry
  localparam int WORD_W = 16;
  localparam int NUM_SLAVES = 16;
  localparam int SLV_W = 4;
  localparam int CNT_W = 5;
  localparam int TYPE_W = 8;
  localparam int NUM_WORDS = 64;
  localparam int IDX_W = 6;

  // Status word layout
  localparam int STAT_W = 24;
  localparam int ST_MISS_LSB = 0;
  localparam int ST_ABSENT_BIT = 4;
  localparam int ST_ACTIVE_BIT = 7;
  localparam int ST_MISMATCH_LSB = 8;
  localparam logic [STAT_W-1:0] STATUS_RESET = 24'h000000;

  // Command word layout
  localparam int CMD_W = 16;
  localparam int CMD_RESTART_BIT = 0;
  localparam int CMD_RESET_BIT = 1;

  typedef enum logic [2:0] {
    SRIO_IDLE,
    SRIO_INIT,
    SRIO_WAIT_DATA,
    SRIO_ACTIVE,
    SRIO_FAILED,
    SRIO_STOPPED
  } srio_state_e;

endpackage

// ---- rtl/srio_sync_rise.sv ----
`timescale 1ns/1ps
module srio_sync_rise (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_async,
  output logic o_rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } srio_sync_s;

  srio_sync_s sync_reg;
  srio_sync_s sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = i_async;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Only the second and third stages are looked at
  assign o_rise = sync_reg.s2 & ~sync_reg.s3;
endmodule

// ---- rtl/srio_word_table.sv ----
`timescale 1ns/1ps
module srio_word_table #(
  parameter int NWORDS = srio_pkg::NUM_WORDS,
  parameter int WW = srio_pkg::WORD_W,
  parameter int IW = srio_pkg::IDX_W
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_wr_en,
  input wire logic [IW-1:0] i_wr_index,
  input wire logic [WW-1:0] i_wr_data,
  input wire logic i_stale,
  input wire logic i_hold,
  input wire logic [IW-1:0] i_rd_index,
  output logic [WW-1:0] o_rd_data
);
  import srio_pkg::*;

  typedef struct packed {
    logic [NWORDS-1:0][WW-1:0] words;
    logic [WW-1:0] rd;
  } srio_table_s;

  srio_table_s tab_reg;
  srio_table_s tab_next;

  always_comb begin
    tab_next = tab_reg;
    // (R8) Whole word written at once
    if (i_wr_en && !i_stale) begin
      tab_next.words[i_wr_index] = i_wr_data;
    end
    // (R21) Zero fill or hold last
    if (i_stale && !i_hold) begin
      tab_next.rd = '0;
    end else begin
      tab_next.rd = tab_reg.words[i_rd_index];
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tab_reg <= '0;
    end else begin
      tab_reg <= tab_next;
    end
  end

  assign o_rd_data = tab_reg.rd;
endmodule

// ---- rtl/srio_master.sv ----
`timescale 1ns/1ps
// What this block does
// (R1) Slave zero data sets link active
// (R2) Slave data lands in assigned input words
// (R3) Stale outputs zeroed or held, one setting
// (R4) Keeps sending outputs while master operates
// (R5) Stale inputs zeroed or held, still supplied
// (R6) Operator clears fault, power-cycles, then restarts
// (R7) Restart may form a shorter link
// (R8) Coherence only within each 16-bit word
// (R9) 24-bit status: health byte plus mismatches
// (R10) Status bit 7 mirrors active indicator
// (R11) Missing slaves set bit 4, link runs
// (R12) Bits 0-3 give lowest missing position
// (R13) Power loss and cable break alike
// (R14) Bits 8-23 flag per-slave mismatch at init
// (R15) Mismatch alone never stops the link
// (R16) Controller checks bit 4 at startup
// (R17) Controller pulses bit 0 to restart
// (R18) Restart only when idle; one-shot commands
// (R19) Reset command stops outputs, clears active (code acts on it only in SRIO_ACTIVE)
// (R20) No transmit before valid controller output
// (R21) One zero/hold setting per direction
module srio_master #(
  parameter int unsigned RX_TIMEOUT_CYCLES = srio_pkg::RX_TIMEOUT_CYC
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_ctrl_run,
  input wire logic i_out_valid,
  input wire logic [srio_pkg::IDX_W-1:0] i_out_index,
  input wire logic [srio_pkg::WORD_W-1:0] i_out_data,
  input wire logic [srio_pkg::CMD_W-1:0] i_cmd,
  input wire logic i_restart_button,
  input wire logic i_in_hold,
  input wire logic i_out_hold,
  input wire logic [srio_pkg::CNT_W-1:0] i_cfg_count,
  input wire logic [srio_pkg::NUM_SLAVES*srio_pkg::TYPE_W-1:0] i_cfg_types,
  input wire logic [srio_pkg::NUM_SLAVES*srio_pkg::IDX_W-1:0] i_cfg_in_base,
  input wire logic i_ident_valid,
  input wire logic [srio_pkg::SLV_W-1:0] i_ident_slave,
  input wire logic [srio_pkg::TYPE_W-1:0] i_ident_type,
  input wire logic i_init_done,
  input wire logic [srio_pkg::CNT_W-1:0] i_found_count,
  input wire logic i_rx_valid,
  input wire logic [srio_pkg::SLV_W-1:0] i_rx_slave,
  input wire logic [srio_pkg::IDX_W-1:0] i_rx_word,
  input wire logic [srio_pkg::WORD_W-1:0] i_rx_data,
  input wire logic [srio_pkg::IDX_W-1:0] i_tx_index,
  input wire logic [srio_pkg::IDX_W-1:0] i_in_rd_index,
  output logic o_link_start,
  output logic o_tx_enable,
  output logic [srio_pkg::WORD_W-1:0] o_tx_data,
  output logic [srio_pkg::WORD_W-1:0] o_in_rd_data,
  output logic [srio_pkg::STAT_W-1:0] o_status,
  output logic o_link_active_indicator
);
  import srio_pkg::*;

  localparam int TMO_W = $clog2(RX_TIMEOUT_CYCLES + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(RX_TIMEOUT_CYCLES - 1);

  typedef struct packed {
    srio_state_e state;
    logic got_out;
    logic [1:0] cmd_prev;
    logic [STAT_W-1:0] status;
    logic [TMO_W-1:0] tmo;
    logic start;
  } srio_main_s;

  srio_main_s m_reg;
  srio_main_s m_next;

  logic btn_rise;
  logic restart_req;
  logic reset_req;
  logic in_stale;
  logic rx_wr;
  logic [IDX_W-1:0] rx_base;
  logic [IDX_W-1:0] rx_index;
  logic [TYPE_W-1:0] cfg_type;

  srio_sync_rise u_button (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_async(i_restart_button),
    .o_rise(btn_rise)
  );

  // (R18) Commands act on rising edge only
  assign restart_req = btn_rise |
    (i_cmd[CMD_RESTART_BIT] & ~m_reg.cmd_prev[0]);
  assign reset_req = i_cmd[CMD_RESET_BIT] & ~m_reg.cmd_prev[1];

  // (R2) Slave base plus word offset
  assign rx_base = i_cfg_in_base[i_rx_slave*IDX_W +: IDX_W];
  assign rx_index = IDX_W'(rx_base + i_rx_word);
  assign cfg_type = i_cfg_types[i_ident_slave*TYPE_W +: TYPE_W];

  // (R5) Inputs stale in every state except SRIO_WAIT_DATA and SRIO_ACTIVE
  assign in_stale = (m_reg.state != SRIO_ACTIVE) && (m_reg.state != SRIO_WAIT_DATA);
  assign rx_wr = i_rx_valid && !in_stale;

  always_comb begin
    m_next = m_reg;
    m_next.start = 1'b0;
    m_next.cmd_prev = {i_cmd[CMD_RESET_BIT], i_cmd[CMD_RESTART_BIT]};
    // (R20) Wait for valid controller output
    if (i_out_valid && i_ctrl_run) begin
      m_next.got_out = 1'b1;
    end
    case (m_reg.state)
      SRIO_IDLE: begin
        if (m_reg.got_out) begin
          m_next.state = SRIO_INIT;
          m_next.start = 1'b1;
          m_next.status = STATUS_RESET;
        end
      end
      SRIO_INIT: begin
        // (R14) Mismatch flags evaluated at init
        if (i_ident_valid && (CNT_W'(i_ident_slave) < i_cfg_count) &&
            (i_ident_type != cfg_type)) begin
          m_next.status[ST_MISMATCH_LSB + int'(i_ident_slave)] = 1'b1;
        end
        if (i_init_done) begin
          // (R15) Mismatches do not block start
          m_next.state = SRIO_WAIT_DATA;
          m_next.tmo = '0;
          // (R11) Absent slaves flagged, link still runs
          if (i_found_count < i_cfg_count) begin
            m_next.status[ST_ABSENT_BIT] = 1'b1;
            // (R12) Lowest missing position
            // (R13) First unreachable slave reported
            m_next.status[ST_MISS_LSB +: 4] = i_found_count[3:0];
          end
        end
      end
      SRIO_WAIT_DATA: begin
        // (R1) First slave zero data
        if (i_rx_valid && (i_rx_slave == '0)) begin
          m_next.state = SRIO_ACTIVE;
          m_next.status[ST_ACTIVE_BIT] = 1'b1;
          m_next.tmo = '0;
        end else if (m_reg.tmo == TMO_LAST) begin
          m_next.state = SRIO_FAILED;
        end else begin
          m_next.tmo = m_reg.tmo + 1'b1;
        end
      end
      SRIO_ACTIVE: begin
        // (R19) Reset command drops the link
        if (reset_req) begin
          m_next.state = SRIO_STOPPED;
          m_next.status[ST_ACTIVE_BIT] = 1'b0;
        end else if (i_rx_valid) begin
          m_next.tmo = '0;
        end else if (m_reg.tmo == TMO_LAST) begin
          // (R10) Link failure clears active bit
          m_next.state = SRIO_FAILED;
          m_next.status[ST_ACTIVE_BIT] = 1'b0;
        end else begin
          m_next.tmo = m_reg.tmo + 1'b1;
        end
      end
      SRIO_FAILED,
      SRIO_STOPPED: begin
        // (R7) No check that faults are gone
        // (R17) Restart accepted only here
        if (restart_req) begin
          m_next.state = SRIO_INIT;
          m_next.start = 1'b1;
          m_next.status = STATUS_RESET;
        end
      end
      default: begin
        m_next.state = SRIO_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      m_reg <= '{state: SRIO_IDLE, got_out: 1'b0, cmd_prev: 2'h0,
                 status: STATUS_RESET, tmo: '0, start: 1'b0};
    end else begin
      m_reg <= m_next;
    end
  end

  // (R3) Output table defaults when controller stops
  srio_word_table #(
    .NWORDS(NUM_WORDS),
    .WW(WORD_W),
    .IW(IDX_W)
  ) u_out_table (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_wr_en(i_out_valid),
    .i_wr_index(i_out_index),
    .i_wr_data(i_out_data),
    .i_stale(~i_ctrl_run),
    .i_hold(i_out_hold),
    .i_rd_index(i_tx_index),
    .o_rd_data(o_tx_data)
  );

  // (R5) Input table keeps feeding the controller
  srio_word_table #(
    .NWORDS(NUM_WORDS),
    .WW(WORD_W),
    .IW(IDX_W)
  ) u_in_table (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_wr_en(rx_wr),
    .i_wr_index(rx_index),
    .i_wr_data(i_rx_data),
    .i_stale(in_stale),
    .i_hold(i_in_hold),
    .i_rd_index(i_in_rd_index),
    .o_rd_data(o_in_rd_data)
  );

  // (R4) Transmit continues through failure, stops on reset command in SRIO_ACTIVE
  assign o_tx_enable = m_reg.got_out && (m_reg.state != SRIO_IDLE) &&
                       (m_reg.state != SRIO_STOPPED);
  assign o_link_start = m_reg.start;
  // (R9) Status word straight from register
  assign o_status = m_reg.status;
  assign o_link_active_indicator = m_reg.status[ST_ACTIVE_BIT];

  AST_ACTIVE_ON_SLAVE0: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R1)
    (m_reg.state == SRIO_WAIT_DATA && i_rx_valid && i_rx_slave == '0)
    |=> (o_status[ST_ACTIVE_BIT] && m_reg.state == SRIO_ACTIVE))
    else $error("link active not set on slave zero data");

  AST_INDICATOR_MIRROR: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R10)
    (o_link_active_indicator == o_status[ST_ACTIVE_BIT]) &&
    (o_status[ST_ACTIVE_BIT] == (m_reg.state == SRIO_ACTIVE)))
    else $error("active indicator disagrees with link state");

  AST_NO_TX_BEFORE_OUTPUT: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R20)
    !m_reg.got_out |-> !o_tx_enable && !o_link_start)
    else $error("transmit before valid output data");

  AST_RESET_STOPS: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R19)
    (m_reg.state == SRIO_ACTIVE && reset_req)
    |=> (!o_tx_enable && !o_status[ST_ACTIVE_BIT])[*2])
    else $error("reset command did not stop link");

  AST_RESTART_IGNORED_ACTIVE: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R18)
    (m_reg.state == SRIO_ACTIVE && restart_req && !reset_req)
    |=> !o_link_start)
    else $error("restart acted on while link active");

  AST_ABSENT_REPORT: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R12)
    (m_reg.state == SRIO_INIT && i_init_done && i_found_count < i_cfg_count)
    |=> (o_status[ST_ABSENT_BIT] && o_status[3:0] == $past(i_found_count[3:0])))
    else $error("absent slave report wrong");

  AST_MISMATCH_FLAG: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R14)
    (m_reg.state == SRIO_INIT && i_ident_valid && CNT_W'(i_ident_slave) < i_cfg_count &&
     i_ident_type != cfg_type)
    |=> o_status[ST_MISMATCH_LSB + int'($past(i_ident_slave))])
    else $error("mismatch bit not set");

  AST_MISMATCH_RUNS: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R15)
    (m_reg.state == SRIO_INIT && i_init_done)
    |=> (m_reg.state == SRIO_WAIT_DATA && o_tx_enable))
    else $error("link stopped after init");

  AST_OUT_ZERO: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R3)
    (!i_ctrl_run && !i_out_hold) |=> o_tx_data == 16'h0000)
    else $error("stale output not zeroed");

  AST_IN_ZERO: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R5)
    (in_stale && !i_in_hold) |=> o_in_rd_data == 16'h0000)
    else $error("stale input not zeroed");

  AST_TX_WHILE_FAILED: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R4)
    (m_reg.state == SRIO_FAILED || m_reg.state == SRIO_ACTIVE) |-> o_tx_enable)
    else $error("transmit dropped while master operating");

  AST_STATUS_SPARE: assert property (@(posedge i_clock) disable iff (!i_arst_n) // (R9)
    o_status[6:5] == 2'h0)
    else $error("unused status bits set");

  COV_LINK_UP: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    m_reg.state == SRIO_WAIT_DATA ##1 m_reg.state == SRIO_ACTIVE);

  COV_LINK_FAIL: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    m_reg.state == SRIO_ACTIVE ##1 m_reg.state == SRIO_FAILED);

  COV_RESET_RESTART: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    m_reg.state == SRIO_STOPPED ##1 m_reg.state == SRIO_INIT);

  COV_ABSENT: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    $rose(o_status[ST_ABSENT_BIT]));
endmodule

// ---- verif/srio_slave_model.sv ----
`timescale 1ns/1ps
module srio_slave_model (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_link_start,
  input wire logic i_tx_enable,
  input wire logic [127:0] i_types,
  input wire logic [4:0] i_found,
  input wire logic i_silent,
  output logic o_ident_valid,
  output logic [3:0] o_ident_slave,
  output logic [7:0] o_ident_type,
  output logic o_init_done,
  output logic [4:0] o_found_count,
  output logic o_rx_valid,
  output logic [3:0] o_rx_slave,
  output logic [5:0] o_rx_word,
  output logic [15:0] o_rx_data
);
  logic [4:0] pos;
  logic busy;
  logic [1:0] gap;
  // Slow answers: one word every four cycles
  always @(negedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pos <= 5'h00;
      busy <= 1'b0;
      gap <= 2'h0;
      o_ident_valid <= 1'b0;
      o_init_done <= 1'b0;
      o_rx_valid <= 1'b0;
      o_found_count <= 5'h00;
      o_ident_slave <= 4'h0;
      o_ident_type <= 8'h00;
      o_rx_slave <= 4'h0;
      o_rx_word <= 6'h00;
      o_rx_data <= 16'h0000;
    end else begin
      o_ident_valid <= 1'b0;
      o_init_done <= 1'b0;
      o_rx_valid <= 1'b0;
      // Idle type and data fields never keep a stale value
      o_ident_type <= ~o_ident_type;
      o_rx_data <= ~o_rx_data;
      if (i_link_start) begin
        busy <= 1'b1;
        pos <= 5'h00;
      end else if (busy) begin
        // Chain ends at first dead slave
        if (pos < i_found) begin
          o_ident_valid <= 1'b1;
          o_ident_slave <= pos[3:0];
          o_ident_type <= i_types[pos*8+:8];
          pos <= pos + 5'h01;
        end else begin
          o_init_done <= 1'b1;
          o_found_count <= i_found;
          busy <= 1'b0;
          pos <= 5'h00;
        end
      end else if (i_tx_enable && !i_silent && i_found != 5'h00) begin
        gap <= gap + 2'h1;
        if (gap == 2'h3) begin
          o_rx_valid <= 1'b1;
          o_rx_slave <= pos[3:0];
          o_rx_word <= 6'h00;
          o_rx_data <= {12'ha50, pos[3:0]};
          pos <= (pos + 5'h01 == i_found) ? 5'h00 : pos + 5'h01;
        end
      end
    end
  end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
  import srio_pkg::*;
  typedef struct packed {logic [5:0] idx; logic [15:0] data;} srio_row_s;
  srio_row_s rows[4] = '{'{6'h00, 16'h1234}, '{6'h3f, 16'hffff}, '{6'h01, 16'h0001},
    '{6'h20, 16'h8000}};
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, ov = 1'b0, btn = 1'b0, silent = 1'b0;
  logic ihold = 1'b0, ohold = 1'b0;
  logic [5:0] oidx = 6'h00, txi = 6'h00, rdi = 6'h00;
  logic [15:0] od = 16'h0000, cmd = 16'h0000;
  logic [4:0] found = 5'h02;
  logic [4:0] ccount = 5'h03;
  logic [127:0] ctypes = 128'h030201, mtypes = 128'h037701;
  logic [95:0] cbase = 96'h10200;
  logic idv, ind, rxv, lstart, txen, ind_led;
  logic [3:0] ids, rxs;
  logic [7:0] idt;
  logic [4:0] fcnt;
  logic [5:0] rxw;
  logic [15:0] rxd, txd, ird;
  logic [23:0] st;
  int fail_count = 0, checks_done = 0, cyc = 0, starts = 0;

  initial forever #10 clk = ~clk;

  srio_master #(.RX_TIMEOUT_CYCLES(20)) uut (.i_clock(clk), .i_arst_n(rst_n),
    .i_ctrl_run(run), .i_out_valid(ov), .i_out_index(oidx), .i_out_data(od), .i_cmd(cmd),
    .i_restart_button(btn), .i_in_hold(ihold), .i_out_hold(ohold), .i_cfg_count(ccount),
    .i_cfg_types(ctypes), .i_cfg_in_base(cbase), .i_ident_valid(idv), .i_ident_slave(ids),
    .i_ident_type(idt), .i_init_done(ind), .i_found_count(fcnt), .i_rx_valid(rxv),
    .i_rx_slave(rxs), .i_rx_word(rxw), .i_rx_data(rxd), .i_tx_index(txi),
    .i_in_rd_index(rdi), .o_link_start(lstart), .o_tx_enable(txen), .o_tx_data(txd),
    .o_in_rd_data(ird), .o_status(st), .o_link_active_indicator(ind_led));

  srio_slave_model slaves (.i_clock(clk), .i_arst_n(rst_n), .i_link_start(lstart),
    .i_tx_enable(txen), .i_types(mtypes), .i_found(found), .i_silent(silent),
    .o_ident_valid(idv), .o_ident_slave(ids), .o_ident_type(idt), .o_init_done(ind),
    .o_found_count(fcnt), .o_rx_valid(rxv), .o_rx_slave(rxs), .o_rx_word(rxw),
    .o_rx_data(rxd));

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse_cmd(input logic [15:0] c);
    cmd = c;
    step(2);
    cmd = 16'h0000;
    step(2);
  endtask

  // Ceiling well above the whole sequence
  always @(posedge clk) begin
    cyc++;
    if (lstart === 1'b1) starts++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    step(12);
    rst_n = 1'b1;
    step(2);
    check("status after reset", st, 24'h000000);
    check("tx enable before data", {23'h0, txen}, 24'h0);
    check("starts before data", 24'(starts), 24'h0);
    run = 1'b1;
    foreach (rows[i]) begin
      ov = 1'b1;
      oidx = rows[i].idx;
      od = rows[i].data;
      step(1);
      ov = 1'b0;
      txi = rows[i].idx;
      step(2);
      check("tx data", {8'h00, txd}, {8'h00, rows[i].data});
    end
    step(20);
    check("starts", 24'(starts), 24'h1);
    // Slave 1 wrong type, slave 2 absent
    check("status short link", st, 24'h000292);
    check("indicator", {23'h0, ind_led}, 24'h1);
    rdi = 6'h00;
    step(2);
    check("input slave0", {8'h00, ird}, 24'h00a500);
    rdi = 6'h08;
    step(2);
    check("input slave1", {8'h00, ird}, 24'h00a501);
    pulse_cmd(16'h0001);
    check("restart while active", 24'(starts), 24'h1);
    run = 1'b0;
    ohold = 1'b1;
    ov = 1'b1;
    oidx = rows[0].idx;
    od = 16'hbeef;
    step(1);
    ov = 1'b0;
    txi = rows[0].idx;
    step(2);
    check("held output", {8'h00, txd}, {8'h00, rows[0].data});
    ohold = 1'b0;
    step(2);
    check("zeroed output", {8'h00, txd}, 24'h0);
    check("tx while stale", {23'h0, txen}, 24'h1);
    run = 1'b1;
    ihold = 1'b1;
    // Model samples on this edge too, so its inputs change late
    silent <= 1'b1;
    rdi = 6'h00;
    step(30);
    check("status link lost", {16'h0, st[7:0]}, 24'h000012);
    check("tx after failure", {23'h0, txen}, 24'h1);
    check("held input", {8'h00, ird}, 24'h00a500);
    ihold = 1'b0;
    step(2);
    check("zeroed input", {8'h00, ird}, 24'h0);
    mtypes <= 128'h030201;
    found <= 5'h03;
    silent <= 1'b0;
    pulse_cmd(16'h0001);
    step(30);
    check("starts after restart", 24'(starts), 24'h2);
    check("status full link", st, 24'h000080);
    pulse_cmd(16'h0002);
    check("tx after reset cmd", {23'h0, txen}, 24'h0);
    check("status after reset cmd", st, 24'h000000);
    // Slave 2 beyond configured count, its type is not judged
    ccount = 5'h02;
    mtypes <= 128'h990201;
    btn = 1'b1;
    step(10);
    btn = 1'b0;
    step(30);
    check("starts after button", 24'(starts), 24'h3);
    check("status after button", st, 24'h000080);
    rst_n = 1'b0;
    step(2);
    check("status in reset", st, 24'h000000);
    check("tx in reset", {23'h0, txen}, 24'h0);
    rst_n = 1'b1;
    step(2);
    check("status after release", st, 24'h000000);
    check("tx after release", {23'h0, txen}, 24'h0);
    end_sim();
  end
endmodule
